// >>> hdl/rx_cfg_pkg.sv
`default_nettype none
package rx_cfg_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int NUM_CH = 4;
	// Register addresses
	localparam logic [ADDR_W-1:0] RX_CTL_ADDR = 10'h01a;
	localparam logic [ADDR_W-1:0] ZD_CTL_ADDR = 10'h01b;
	// Reset values, write masks and unmapped read value
	localparam logic [DATA_W-1:0] RX_CTL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] ZD_CTL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] RX_CTL_WMASK = 8'hff;
	localparam logic [DATA_W-1:0] ZD_CTL_WMASK = 8'h3f;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
	// Receiver control fields
	localparam int CTL_TEST_EN = 7;
	localparam int CTL_B_DIFF = 6;
	localparam int CTL_A_DIFF = 5;
	localparam int CTL_B_EN = 4;
	localparam int CTL_A_EN = 3;
	localparam int CTL_PD_CTRL = 2;
	localparam int CTL_OSC_NEG = 1;
	localparam int CTL_OSC_DIFF = 0;
	// Zero delay control fields
	localparam int ZD_MODE_INT = 5;
	localparam int ZD_FB_OSC = 4;
	localparam int ZD_SE_PIN = 3;
	localparam int ZD_DIFF = 2;
	localparam int ZD_B_PIN = 1;
	localparam int ZD_A_PIN = 0;
	// Receiver channel indices
	localparam int CH_PRI = 0;
	localparam int CH_SEC = 1;
	localparam int CH_OSC = 2;
	localparam int CH_ZD = 3;
endpackage
`default_nettype wire

// >>> hdl/cfg_regs_if.sv
`default_nettype none
interface cfg_regs_if;
	import rx_cfg_pkg::*;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic io_update;
	logic [DATA_W-1:0] buf_ctl;
	logic [DATA_W-1:0] buf_zd;
	logic [DATA_W-1:0] act_ctl;
	logic [DATA_W-1:0] act_zd;
	modport store (
		input wr_en, wr_addr, wr_data, io_update,
		output buf_ctl, buf_zd, act_ctl, act_zd
	);
	modport user (
		output wr_en, wr_addr, wr_data, io_update,
		input buf_ctl, buf_zd, act_ctl, act_zd
	);
endinterface
`default_nettype wire

// >>> hdl/cfg_shadow_regs.sv
`default_nettype none
module cfg_shadow_regs
	import rx_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register storage
	cfg_regs_if.store regs
);
	typedef struct packed {
		logic [DATA_W-1:0] buf_ctl;
		logic [DATA_W-1:0] buf_zd;
		logic [DATA_W-1:0] act_ctl;
		logic [DATA_W-1:0] act_zd;
	} shadow_t;

	shadow_t s_q;
	shadow_t s_d;

	always_comb begin
		s_d = s_q;
		if (regs.wr_en && regs.wr_addr == RX_CTL_ADDR) begin
			s_d.buf_ctl = regs.wr_data & RX_CTL_WMASK;
		end
		if (regs.wr_en && regs.wr_addr == ZD_CTL_ADDR) begin
			s_d.buf_zd = regs.wr_data & ZD_CTL_WMASK;
		end
		// A write in the update cycle goes live at once
		if (regs.io_update) begin
			s_d.act_ctl = s_d.buf_ctl;
			s_d.act_zd = s_d.buf_zd;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q <= '{RX_CTL_RESET, ZD_CTL_RESET, RX_CTL_RESET, ZD_CTL_RESET};
		end else begin
			s_q <= s_d;
		end
	end

	assign regs.buf_ctl = s_q.buf_ctl;
	assign regs.buf_zd = s_q.buf_zd;
	assign regs.act_ctl = s_q.act_ctl;
	assign regs.act_zd = s_q.act_zd;
endmodule
`default_nettype wire

// >>> hdl/rx_mode_decode.sv
`default_nettype none
module rx_mode_decode (
	// Raw fields
	input wire logic diff_i,
	input wire logic pin_i,
	input wire logic en_i,
	// Decoded mode
	output logic en_o,
	output logic diff_o,
	output logic se_pin_o
);
	// Pin choice only matters in single-ended mode
	assign en_o = en_i;
	assign diff_o = diff_i;
	assign se_pin_o = !diff_i && pin_i;
endmodule
`default_nettype wire

// >>> hdl/reference_input_receiver_config.sv
`default_nettype none
// Function
// - Test receiver powered only while bit 7 set
// - Bit 6 makes secondary reference differential
// - Bit 5 makes primary reference differential
// - Bit 2 low keeps both references enabled
// - Bit 4 enables secondary under individual control
// - Bit 3 enables primary under individual control
// - Bit 1 picks oscillator negative single-ended pin
// - Bit 0 makes oscillator input differential
// - Mode bit picks internal or external feedback
// - Mode bit ignored when oscillator feeds back
// - Bit 4 routes oscillator into loop feedback
// - Bit 2 makes zero-delay receiver differential
// - Bit 3 pin choice only when single-ended
// - Bit 1 picks secondary single-ended pin
// - Bit 0 picks primary single-ended pin
// - Writes buffered until update; optional buffered readback
module reference_input_receiver_config
	import rx_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register write port
	input wire logic wr_en_i,
	input wire logic [rx_cfg_pkg::ADDR_W-1:0] wr_addr_i,
	input wire logic [rx_cfg_pkg::DATA_W-1:0] wr_data_i,
	input wire logic io_update_i,
	// Register read port
	input wire logic rd_en_i,
	input wire logic [rx_cfg_pkg::ADDR_W-1:0] rd_addr_i,
	input wire logic rd_buffered_i,
	output logic [rx_cfg_pkg::DATA_W-1:0] rd_data_o,
	output logic rd_valid_o,
	// Receiver controls, indexed by channel
	output logic [rx_cfg_pkg::NUM_CH-1:0] rx_en_o,
	output logic [rx_cfg_pkg::NUM_CH-1:0] rx_diff_o,
	output logic [rx_cfg_pkg::NUM_CH-1:0] rx_se_pin_o,
	// Test receiver and feedback path
	output logic ref_test_en_o,
	output logic fb_from_osc_o,
	output logic zd_internal_o
);
	typedef struct packed {
		logic [DATA_W-1:0] rd_data;
		logic rd_valid;
		logic [NUM_CH-1:0] rx_en;
		logic [NUM_CH-1:0] rx_diff;
		logic [NUM_CH-1:0] rx_se_pin;
		logic ref_test_en;
		logic fb_from_osc;
		logic zd_internal;
	} top_state_t;

	top_state_t t_q;
	top_state_t t_d;
	cfg_regs_if regs ();
	logic [NUM_CH-1:0] raw_diff;
	logic [NUM_CH-1:0] raw_pin;
	logic [NUM_CH-1:0] raw_en;
	logic [NUM_CH-1:0] dec_en;
	logic [NUM_CH-1:0] dec_diff;
	logic [NUM_CH-1:0] dec_pin;
	logic [DATA_W-1:0] ctl;
	logic [DATA_W-1:0] zd;

	assign regs.wr_en = wr_en_i;
	assign regs.wr_addr = wr_addr_i;
	assign regs.wr_data = wr_data_i;
	assign regs.io_update = io_update_i;

	cfg_shadow_regs u_shadow (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.regs(regs)
	);

	// Decode always works from the live copy, never the buffer
	assign ctl = regs.act_ctl;
	assign zd = regs.act_zd;

	always_comb begin
		raw_diff[CH_PRI] = ctl[CTL_A_DIFF];
		raw_pin[CH_PRI] = zd[ZD_A_PIN];
		raw_en[CH_PRI] = ctl[CTL_PD_CTRL] ? ctl[CTL_A_EN] : 1'b1;
		raw_diff[CH_SEC] = ctl[CTL_B_DIFF];
		raw_pin[CH_SEC] = zd[ZD_B_PIN];
		raw_en[CH_SEC] = ctl[CTL_PD_CTRL] ? ctl[CTL_B_EN] : 1'b1;
		raw_diff[CH_OSC] = ctl[CTL_OSC_DIFF];
		raw_pin[CH_OSC] = ctl[CTL_OSC_NEG];
		raw_en[CH_OSC] = 1'b1;
		raw_diff[CH_ZD] = zd[ZD_DIFF];
		raw_pin[CH_ZD] = zd[ZD_SE_PIN];
		// Powered only for external zero delay
		raw_en[CH_ZD] = !zd[ZD_FB_OSC] && !zd[ZD_MODE_INT];
	end

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			rx_mode_decode u_dec (
				.diff_i(raw_diff[ch]),
				.pin_i(raw_pin[ch]),
				.en_i(raw_en[ch]),
				.en_o(dec_en[ch]),
				.diff_o(dec_diff[ch]),
				.se_pin_o(dec_pin[ch])
			);
		end
	endgenerate

	always_comb begin
		t_d = t_q;
		t_d.rx_en = dec_en;
		t_d.rx_diff = dec_diff;
		t_d.rx_se_pin = dec_pin;
		t_d.ref_test_en = ctl[CTL_TEST_EN];
		t_d.fb_from_osc = zd[ZD_FB_OSC];
		t_d.zd_internal = !zd[ZD_FB_OSC] && zd[ZD_MODE_INT];
		t_d.rd_valid = rd_en_i;
		if (rd_en_i) begin
			if (rd_addr_i == RX_CTL_ADDR) begin
				t_d.rd_data = rd_buffered_i ? regs.buf_ctl : regs.act_ctl;
			end else if (rd_addr_i == ZD_CTL_ADDR) begin
				// Reserved bits never stored, so they read zero
				t_d.rd_data = rd_buffered_i ? regs.buf_zd : regs.act_zd;
			end else begin
				t_d.rd_data = UNMAPPED_READ;
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			t_q.rd_data <= UNMAPPED_READ;
			t_q.rd_valid <= 1'b0;
			t_q.rx_en <= '0;
			t_q.rx_diff <= '0;
			t_q.rx_se_pin <= '0;
			t_q.ref_test_en <= 1'b0;
			t_q.fb_from_osc <= 1'b0;
			t_q.zd_internal <= 1'b0;
		end else begin
			t_q <= t_d;
		end
	end

	assign rd_data_o = t_q.rd_data;
	assign rd_valid_o = t_q.rd_valid;
	assign rx_en_o = t_q.rx_en;
	assign rx_diff_o = t_q.rx_diff;
	assign rx_se_pin_o = t_q.rx_se_pin;
	assign ref_test_en_o = t_q.ref_test_en;
	assign fb_from_osc_o = t_q.fb_from_osc;
	assign zd_internal_o = t_q.zd_internal;
endmodule
`default_nettype wire

// >>> dv/reference_input_receiver_config_properties.sv
`default_nettype none
module rx_cfg_checker
	import rx_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register port
	input wire logic io_update_i,
	input wire logic rd_en_i,
	input wire logic [rx_cfg_pkg::ADDR_W-1:0] rd_addr_i,
	input wire logic [rx_cfg_pkg::DATA_W-1:0] rd_data_o,
	input wire logic rd_valid_o,
	// Decoded controls
	input wire logic [rx_cfg_pkg::NUM_CH-1:0] rx_en_o,
	input wire logic [rx_cfg_pkg::NUM_CH-1:0] rx_diff_o,
	input wire logic [rx_cfg_pkg::NUM_CH-1:0] rx_se_pin_o,
	input wire logic ref_test_en_o,
	input wire logic fb_from_osc_o,
	input wire logic zd_internal_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Outputs settle one edge after release, so hold checks wait
	logic [1:0] age_q;
	logic [1:0] age_d;
	always_comb age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) age_q <= 2'h0;
		else age_q <= age_d;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	a_pin_when_diff: assert property ((rx_se_pin_o & rx_diff_o) == 4'h0)
		else $error("pin select while differential");
	a_zd_internal_off: assert property (zd_internal_o |-> !fb_from_osc_o && !rx_en_o[CH_ZD])
		else $error("internal feedback with receiver on");
	a_osc_fb_wins: assert property (fb_from_osc_o |-> !rx_en_o[CH_ZD] && !zd_internal_o)
		else $error("zero delay mode not ignored");
	a_osc_always_on: assert property (age_q == 2'h3 |-> rx_en_o[CH_OSC])
		else $error("oscillator receiver off");
	a_read_valid: assert property (rd_en_i |=> rd_valid_o)
		else $error("read not answered");
	a_read_once: assert property (!rd_en_i |=> !rd_valid_o)
		else $error("stray read valid");
	a_unmapped_zero: assert property (rd_en_i && rd_addr_i != RX_CTL_ADDR &&
		rd_addr_i != ZD_CTL_ADDR |=> rd_data_o == UNMAPPED_READ)
		else $error("unmapped read not zero");
	a_reserved_zero: assert property (rd_en_i && rd_addr_i == ZD_CTL_ADDR |=>
		rd_data_o[7:6] == 2'h0)
		else $error("reserved bits read nonzero");
	a_live_hold: assert property (age_q == 2'h3 && !$past(io_update_i, 2) |->
		$stable({rx_en_o, rx_diff_o, rx_se_pin_o, ref_test_en_o, fb_from_osc_o, zd_internal_o}))
		else $error("controls moved without update");
	a_data_hold: assert property (!rd_en_i |=> $stable(rd_data_o))
		else $error("read data moved without read");
endmodule
bind reference_input_receiver_config rx_cfg_checker u_rx_cfg_checker (.clk_i, .resetn_i,
	.io_update_i, .rd_en_i, .rd_addr_i, .rd_data_o, .rd_valid_o, .rx_en_o, .rx_diff_o,
	.rx_se_pin_o, .ref_test_en_o, .fb_from_osc_o, .zd_internal_o);
`default_nettype wire

// >>> dv/test_reference_input_receiver_config.sv
`default_nettype none
module test_reference_input_receiver_config;
	timeunit 1ns;
	timeprecision 1ps;
	import rx_cfg_pkg::*;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic wr_en_i = 1'b0;
	logic [ADDR_W-1:0] wr_addr_i = 10'h000;
	logic [DATA_W-1:0] wr_data_i = 8'h00;
	logic io_update_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic [ADDR_W-1:0] rd_addr_i = 10'h000;
	logic rd_buffered_i = 1'b0;
	logic [DATA_W-1:0] rd_data_o;
	logic rd_valid_o;
	logic [NUM_CH-1:0] rx_en_o, rx_diff_o, rx_se_pin_o;
	logic ref_test_en_o, fb_from_osc_o, zd_internal_o;
	logic [14:0] outs;
	logic [7:0] lc, lz;
	// Uneven primary and secondary settings so a swapped channel shows
	logic [7:0] ctl_v [6] = '{8'hff, 8'h0c, 8'h04, 8'h82, 8'h69, 8'h34};
	logic [7:0] zd_v [6] = '{8'hff, 8'h20, 8'h0b, 8'h10, 8'h24, 8'h02};
	int bad_count = 0;
	int check_count = 0;
	assign outs = {ref_test_en_o, fb_from_osc_o, zd_internal_o, rx_en_o, rx_diff_o, rx_se_pin_o};
	always #2.5 clk_i = ~clk_i;
	reference_input_receiver_config u_reference_input_receiver_config (.clk_i, .resetn_i,
		.wr_en_i, .wr_addr_i, .wr_data_i, .io_update_i, .rd_en_i, .rd_addr_i, .rd_buffered_i,
		.rd_data_o, .rd_valid_o, .rx_en_o, .rx_diff_o, .rx_se_pin_o, .ref_test_en_o,
		.fb_from_osc_o, .zd_internal_o);
	// Expected controls from live register values
	function automatic logic [14:0] dec(input logic [7:0] c, input logic [7:0] z);
		return {c[7], z[4], !z[4] & z[5], !z[4] & !z[5], 1'b1, c[2] ? c[4] : 1'b1,
			c[2] ? c[3] : 1'b1, z[2], c[0], c[6], c[5], z[3] & !z[2], c[1] & !c[0],
			z[1] & !c[6], z[0] & !c[5]};
	endfunction
	task automatic cmp(input string what, input logic [14:0] exp, input logic [14:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_rd(input string what, input logic [7:0] exp, input logic got_v,
		input logic [7:0] got);
		check_count++;
		if (got_v !== 1'b1 || got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h valid %b", what, exp, got, got_v);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_en_i <= 1'b1;
		wr_addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
	endtask
	// Valid is a one-cycle pulse, so it is looked at just after its edge
	task automatic rd(input logic [9:0] a, input logic b, input logic [7:0] e);
		@(posedge clk_i);
		rd_en_i <= 1'b1;
		rd_addr_i <= a;
		rd_buffered_i <= b;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1;
		cmp_rd("read", e, rd_valid_o, rd_data_o);
	endtask
	task automatic upd;
		@(posedge clk_i);
		io_update_i <= 1'b1;
		@(posedge clk_i);
		io_update_i <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		lc = RX_CTL_RESET;
		lz = ZD_CTL_RESET;
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		#1;
		cmp("reset decode", dec(lc, lz), outs);
		rd(RX_CTL_ADDR, 1'b0, RX_CTL_RESET);
		rd(ZD_CTL_ADDR, 1'b1, ZD_CTL_RESET);
		foreach (ctl_v[i]) begin
			wr(RX_CTL_ADDR, ctl_v[i]);
			wr(ZD_CTL_ADDR, zd_v[i]);
			#1 cmp("held", dec(lc, lz), outs);
			rd(ZD_CTL_ADDR, 1'b1, zd_v[i] & 8'h3f);
			rd(ZD_CTL_ADDR, 1'b0, lz);
			upd();
			lc = ctl_v[i];
			lz = zd_v[i] & 8'h3f;
			cmp("decode", dec(lc, lz), outs);
			rd(RX_CTL_ADDR, 1'b0, lc);
		end
		// Unmapped write must leave both registers alone
		wr(10'h01c, 8'hff);
		rd(10'h01c, 1'b1, UNMAPPED_READ);
		upd();
		cmp("unmapped", dec(lc, lz), outs);
		complete_run();
	end
endmodule
`default_nettype wire
